/* File: src/atc_map.vh */
// Register map, field positions and timing counts of the converter control
`ifndef ATC_MAP_VH
`define ATC_MAP_VH
`define ATC_IDX_DIS       8'h17
`define ATC_IDX_RESULT    8'h19
`define ATC_IDX_CHAN      8'h1B
`define ATC_IDX_TRIG      8'h1C
`define ATC_IDX_CTRL      8'h1D
`define ATC_IDX_SAMPLE    8'h20
`define ATC_RST_BYTE      8'h00
`define ATC_CTRL_EN       7
`define ATC_CTRL_START    6
`define ATC_CTRL_AUTO     5
`define ATC_CTRL_DONE     4
`define ATC_CTRL_IE       3
`define ATC_TRIG_FREE     3'h0
`define ATC_CYC_FIRST     5'h19
`define ATC_CYC_NORMAL    5'h0D
`define ATC_ONE5          5'h01
`define ATC_PS_W          7
`endif

/* File: src/atc_prescaler.v */
// Converter clock prescaler producing one tick per converter clock period
`timescale 1ns/1ps
module atc_prescaler (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       run,
    input  wire [2:0] div_sel,
    output reg        tick
);
`include "atc_map.vh"
    reg  [`ATC_PS_W-1:0] count_reg;
    wire [`ATC_PS_W-1:0] limit;

    // Codes 0 and 1 both divide by two
    function [`ATC_PS_W-1:0] div_limit;
        input [2:0] sel;
        begin
            if (sel == 3'h0)
                div_limit = 7'h01;
            else
                div_limit = (7'h01 << sel) - 7'h01;
        end
    endfunction

    assign limit = div_limit(div_sel);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 7'h00;
            tick      <= 1'b0;
        end else if (!run) begin
            count_reg <= 7'h00;
            tick      <= 1'b0;
        end else if (count_reg >= limit) begin
            count_reg <= 7'h00;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 7'h01;
            tick      <= 1'b0;
        end
    end
endmodule

/* File: src/atc_sync3.v */
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module atc_sync3 #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         reset_n,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] s1_reg;
    reg [W-1:0] s2_reg;
    reg [W-1:0] s3_reg;
    genvar i;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= {W{1'b0}};
            s2_reg <= {W{1'b0}};
            s3_reg <= {W{1'b0}};
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n)
                    dout[i] <= 1'b0;
                else if (s2_reg[i] == s3_reg[i])
                    dout[i] <= s3_reg[i];
            end
        end
    endgenerate
endmodule

/* File: src/atc_top.v */
// Converter control: registers, triggering, sequencing and input gating
// Function
// - Done flag sets as the conversion ends and result is stored.
// - Interrupt request while flag, enable and global enable are all set.
// - Taking the interrupt vector clears the done flag.
// - Writing one clears the done flag; writing zero leaves it.
// - Prescaler divides by 2,2,4,8,16,32,64,128 per 3-bit code.
// - Trigger field is ignored unless auto trigger is enabled.
// - Auto conversion starts on a rising edge of the selected flag.
// - Switching selection from clear to set source counts as an edge.
// - Switching to free running makes no trigger event.
// - Trigger codes: free, comparator, ext0, cmpA, ovf, cmpB, pin, capture.
// - Read-only result register holds latest result, resets to zero.
// - Set disable bit gates pin input buffer and reads port bit as zero.
// - Disable bits 3..0 map to pins 3..0; bits 0,1 serve comparator.
// - Enable powers converter; clearing it aborts a running conversion.
// - Start bit starts conversion, reads one while busy, clears at end.
// - First conversion after enable takes 25 cycles, then 13 cycles.
// - Channel change during a conversion waits until it completes.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module atc_top (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        global_irq_enable,
    input  wire        irq_vector_taken,
    input  wire [6:0]  trigger_flags,
    input  wire [3:0]  pin_in,
    input  wire [7:0]  sample_data,
    output reg  [3:0]  port_in_bits,
    output reg  [3:0]  input_buffer_enable,
    output reg         comparator_input_a_buf_en,
    output reg         comparator_input_b_buf_en,
    output reg         converter_power,
    output reg  [1:0]  active_channel,
    output reg         sample_strobe,
    output reg         conversion_irq
);
`include "atc_map.vh"
    reg  [7:0] ctrl_reg;
    reg  [7:0] trig_reg;
    reg  [7:0] dis_reg;
    reg  [7:0] result_reg;
    reg  [1:0] chan_reg;
    reg        busy_reg;
    reg        first_reg;
    reg  [4:0] cyc_reg;
    reg        trig_prev_reg;
    reg  [7:0] rdata_next;
    wire       tick;
    wire [3:0] pin_sync;
    wire       access;
    wire       wr;
    wire [7:0] idx;
    wire       mapped;
    wire       trig_now;
    wire       trig_edge;
    wire       soft_start;
    wire       start;
    wire       finish;
    wire       clr_done_wr;
    wire       conv_en;

    // Printed offsets are word indices; byte address is four times index
    function [7:0] word_index;
        input [31:0] a;
        begin
            word_index = a[9:2];
        end
    endfunction

    function is_mapped;
        input [7:0] i;
        begin
            is_mapped = (i == `ATC_IDX_DIS) || (i == `ATC_IDX_RESULT) ||
                        (i == `ATC_IDX_CHAN) || (i == `ATC_IDX_TRIG) ||
                        (i == `ATC_IDX_CTRL);
        end
    endfunction

    // Index 0 is free running and has no flag of its own
    function select_flag;
        input [2:0] sel;
        input [6:0] flags;
        begin
            if (sel == `ATC_TRIG_FREE)
                select_flag = 1'b0;
            else
                select_flag = flags[sel - 3'h1];
        end
    endfunction

    atc_prescaler u_prescaler (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (conv_en),
        .div_sel (ctrl_reg[2:0]),
        .tick    (tick)
    );

    atc_sync3 #(.W(4)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (pin_in),
        .dout    (pin_sync)
    );

    // One wait state: pready answers in the second access cycle
    assign access = psel && penable && !pready;
    assign idx    = word_index(paddr);
    assign mapped = is_mapped(idx) && (paddr[31:10] == 22'h0) &&
                    (paddr[1:0] == 2'h0);
    // Writes land on the edge that completes the transfer, never earlier
    assign wr     = psel && penable && pready && pwrite && mapped;
    assign conv_en = ctrl_reg[`ATC_CTRL_EN];

    assign clr_done_wr = wr && (idx == `ATC_IDX_CTRL) &&
                         pwdata[`ATC_CTRL_DONE];
    assign soft_start  = wr && (idx == `ATC_IDX_CTRL) &&
                         pwdata[`ATC_CTRL_START] && pwdata[`ATC_CTRL_EN];

    // Free running restarts on the done flag; other codes use the flags
    assign trig_now = (trig_reg[2:0] == `ATC_TRIG_FREE) ?
                      ctrl_reg[`ATC_CTRL_DONE] :
                      select_flag(trig_reg[2:0], trigger_flags);
    assign trig_edge = ctrl_reg[`ATC_CTRL_AUTO] && conv_en &&
                       (trig_reg[2:0] == `ATC_TRIG_FREE ?
                        (ctrl_reg[`ATC_CTRL_DONE] &&
                         ctrl_reg[`ATC_CTRL_START]) :
                        (trig_now && !trig_prev_reg));
    // Start bit stays armed in free running after the first conversion
    assign start  = !busy_reg && (soft_start || trig_edge);
    assign finish = busy_reg && tick && (cyc_reg == `ATC_ONE5) && conv_en;

    // Previous sample tracks the selected source, so a reselect is an edge
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            trig_prev_reg <= 1'b0;
        else if (trig_reg[2:0] == `ATC_TRIG_FREE)
            trig_prev_reg <= 1'b1;
        else
            trig_prev_reg <= trig_now;
    end

    // Conversion sequencer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_reg   <= 1'b0;
            first_reg  <= 1'b1;
            cyc_reg    <= 5'h00;
            result_reg <= `ATC_RST_BYTE;
            sample_strobe <= 1'b0;
        end else if (!conv_en && !soft_start) begin
            busy_reg   <= 1'b0;
            first_reg  <= 1'b1;
            cyc_reg    <= 5'h00;
            sample_strobe <= 1'b0;
        end else if (start) begin
            busy_reg   <= 1'b1;
            cyc_reg    <= first_reg ? `ATC_CYC_FIRST :
                                      `ATC_CYC_NORMAL;
            first_reg  <= 1'b0;
            sample_strobe <= 1'b0;
        end else if (finish) begin
            busy_reg   <= 1'b0;
            cyc_reg    <= 5'h00;
            result_reg <= sample_data;
            sample_strobe <= 1'b1;
        end else begin
            if (busy_reg && tick)
                cyc_reg <= cyc_reg - `ATC_ONE5;
            sample_strobe <= 1'b0;
        end
    end

    // Control and status register
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `ATC_RST_BYTE;
        end else begin
            if (wr && (idx == `ATC_IDX_CTRL)) begin
                ctrl_reg[`ATC_CTRL_EN]   <= pwdata[`ATC_CTRL_EN];
                ctrl_reg[`ATC_CTRL_AUTO] <= pwdata[`ATC_CTRL_AUTO];
                ctrl_reg[`ATC_CTRL_IE]   <= pwdata[`ATC_CTRL_IE];
                ctrl_reg[2:0]            <= pwdata[2:0];
            end
            // Set beats any clear in the same cycle
            if (finish)
                ctrl_reg[`ATC_CTRL_DONE] <= 1'b1;
            else if (clr_done_wr || irq_vector_taken)
                ctrl_reg[`ATC_CTRL_DONE] <= 1'b0;
            if (soft_start || start)
                ctrl_reg[`ATC_CTRL_START] <= 1'b1;
            else if ((finish && !(ctrl_reg[`ATC_CTRL_AUTO] &&
                      trig_reg[2:0] == `ATC_TRIG_FREE)) || !conv_en)
                ctrl_reg[`ATC_CTRL_START] <= 1'b0;
        end
    end

    // Other writable registers; channel select applies only when idle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_reg       <= `ATC_RST_BYTE;
            dis_reg        <= `ATC_RST_BYTE;
            chan_reg       <= 2'h0;
            active_channel <= 2'h0;
        end else begin
            if (wr && (idx == `ATC_IDX_TRIG))
                trig_reg <= {5'h00, pwdata[2:0]};
            if (wr && (idx == `ATC_IDX_DIS))
                dis_reg <= {4'h0, pwdata[3:0]};
            if (wr && (idx == `ATC_IDX_CHAN))
                chan_reg <= pwdata[1:0];
            if (!busy_reg || finish)
                active_channel <= chan_reg;
        end
    end

    always @* begin
        rdata_next = `ATC_RST_BYTE;
        case (idx)
            `ATC_IDX_DIS:    rdata_next = dis_reg;
            `ATC_IDX_RESULT: rdata_next = result_reg;
            `ATC_IDX_CHAN:   rdata_next = {6'h00, chan_reg};
            `ATC_IDX_TRIG:   rdata_next = trig_reg;
            `ATC_IDX_CTRL:   rdata_next = ctrl_reg;
            default:         rdata_next = `ATC_RST_BYTE;
        endcase
    end

    // Bus answer, interrupt and pin-facing outputs
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            conversion_irq <= 1'b0;
            port_in_bits <= 4'h0;
            input_buffer_enable <= 4'h0;
            comparator_input_a_buf_en <= 1'b0;
            comparator_input_b_buf_en <= 1'b0;
            converter_power <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access && !mapped;
            prdata  <= (access && !pwrite && mapped) ?
                       {24'h000000, rdata_next} : 32'h0000_0000;
            conversion_irq <= ctrl_reg[`ATC_CTRL_DONE] &&
                              ctrl_reg[`ATC_CTRL_IE] &&
                              global_irq_enable;
            port_in_bits <= pin_sync & ~dis_reg[3:0];
            input_buffer_enable <= ~dis_reg[3:0];
            comparator_input_a_buf_en <= ~dis_reg[0];
            comparator_input_b_buf_en <= ~dis_reg[1];
            converter_power <= conv_en;
        end
    end
endmodule

/* File: verif/atc_checker.sv */
// Port assertions for the converter control block
`timescale 1ns/1ps
module atc_checker (
    input logic        clk,
    input logic        reset_n,
    input logic        psel,
    input logic        penable,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        global_irq_enable,
    input logic [3:0]  port_in_bits,
    input logic [3:0]  input_buffer_enable,
    input logic        comparator_input_a_buf_en,
    input logic        comparator_input_b_buf_en,
    input logic        converter_power,
    input logic        sample_strobe,
    input logic        conversion_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    answer_time_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    irq_gate_a: assert property (
        conversion_irq |-> $past(global_irq_enable))
        else $error("irq without global enable");
    input_gate_a: assert property (
        (port_in_bits & ~input_buffer_enable) == 4'h0)
        else $error("disabled pin reads one");
    comp_map_a: assert property (
        comparator_input_a_buf_en == input_buffer_enable[0] &&
        comparator_input_b_buf_en == input_buffer_enable[1])
        else $error("comparator buffer mismatch");
    strobe_pulse_a: assert property (
        sample_strobe |=> !sample_strobe [*8])
        else $error("strobe too close");
    off_quiet_a: assert property (
        !converter_power [*3] |-> !sample_strobe)
        else $error("strobe while off");
    cover property ($rose(sample_strobe));
    cover property (pslverr);
    cover property (conversion_irq);
endmodule
bind atc_top atc_checker atc_checker_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_enable(global_irq_enable),
    .port_in_bits(port_in_bits), .input_buffer_enable(input_buffer_enable),
    .comparator_input_a_buf_en(comparator_input_a_buf_en),
    .comparator_input_b_buf_en(comparator_input_b_buf_en),
    .converter_power(converter_power), .sample_strobe(sample_strobe),
    .conversion_irq(conversion_irq));

/* File: verif/atc_core_model.sv */
// Analog core stand-in returning a per-channel sample
`timescale 1ns/1ps
module atc_core_model (
    input  logic       clk,
    input  logic       converter_power,
    input  logic [1:0] active_channel,
    output logic [7:0] sample_data
);
    logic t = 1'h0;
    // Unpowered core shows a toggling pattern, never a held value
    always @(posedge clk) t <= ~t;
    assign sample_data = converter_power ? {active_channel, 6'h15} : {8{t}};
endmodule

/* File: verif/tb_atc_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "atc_map.vh"
module tb_atc_top;
    logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic        pready, pslverr, gie = 0, vt = 0, pw, ca, cb, ss, irq;
    logic [6:0]  tf = 0;
    logic [3:0]  pin = 0, pib, ibe;
    logic [7:0]  sd;
    logic [1:0]  ach;
    int          num_errors = 0, checks = 0;
    atc_top atc_top_inst (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(gie), .irq_vector_taken(vt),
        .trigger_flags(tf), .pin_in(pin), .sample_data(sd),
        .port_in_bits(pib), .input_buffer_enable(ibe),
        .comparator_input_a_buf_en(ca), .comparator_input_b_buf_en(cb),
        .converter_power(pw), .active_channel(ach), .sample_strobe(ss),
        .conversion_irq(irq));
    atc_core_model atc_core_model_inst (.clk(clk), .converter_power(pw),
        .active_channel(ach), .sample_data(sd));
    initial forever #20 clk = ~clk;
    task automatic chk(input string s, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, hi, g);
        checks++;
        if (g < lo || g > hi) begin
            num_errors++;
            $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, g);
        end
    endtask
    // Registers sit at four times their index; data rides in bits 7:0
    task automatic bus(input logic w, input logic [7:0] i, d,
                       output logic [7:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {22'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        chk("pready", 1'h1, pready);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] i, d);
        logic [7:0] q;
        logic e;
        bus(1'h1, i, d, q, e);
    endtask
    task automatic rd(input logic [7:0] i, output logic [7:0] q);
        logic e;
        bus(1'h0, i, 8'h00, q, e);
    endtask
    task automatic wait_ss(input int lim, output int n);
        n = 0;
        while (ss !== 1'h1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_regs();
        logic [7:0] q;
        logic e;
        logic [7:0] idx [5] = '{`ATC_IDX_DIS, `ATC_IDX_RESULT,
            `ATC_IDX_CHAN, `ATC_IDX_TRIG, `ATC_IDX_CTRL};
        foreach (idx[k]) begin
            rd(idx[k], q);
            chk("reset value", `ATC_RST_BYTE, q);
        end
        wr(`ATC_IDX_RESULT, 8'hFF);
        rd(`ATC_IDX_RESULT, q);
        chk("result write", 8'h00, q);
        bus(1'h0, 8'h30, 8'h00, q, e);
        chk("unmapped", 9'h100, {e, q});
    endtask
    task automatic t_dis();
        pin <= 4'hF;
        wr(`ATC_IDX_DIS, 8'h05);
        repeat (6) @(posedge clk);
        chk("port bits", 4'hA, pib);
        chk("buffers", {4'hA, 2'h1}, {ibe, ca, cb});
    endtask
    task automatic t_conv();
        int n;
        logic [7:0] q;
        wr(`ATC_IDX_CTRL, 8'hC0);
        wait_ss(3000, n);
        rng("first conv", 45, 55, n);
        rd(`ATC_IDX_RESULT, q);
        chk("result", 8'h15, q);
        rd(`ATC_IDX_CTRL, q);
        chk("ctrl done", 8'h90, q);
        wr(`ATC_IDX_CTRL, 8'hC3);
        wr(`ATC_IDX_CHAN, 8'h02);
        chk("chan held", 2'h0, ach);
        wait_ss(3000, n);
        rng("normal conv", 94, 112, n);
        rd(`ATC_IDX_CTRL, q);
        chk("done kept", 8'h93, q);
        chk("chan moved", 2'h2, ach);
    endtask
    task automatic t_irq();
        int n;
        logic [7:0] q;
        gie <= 1'h1;
        wr(`ATC_IDX_CTRL, 8'h8B);
        repeat (2) @(posedge clk);
        chk("irq on", 1'h1, irq);
        gie <= 1'h0;
        repeat (2) @(posedge clk);
        chk("irq off", 1'h0, irq);
        wr(`ATC_IDX_CTRL, 8'h9B);
        rd(`ATC_IDX_CTRL, q);
        chk("clear by one", 8'h8B, q);
        wr(`ATC_IDX_CTRL, 8'hCB);
        wait_ss(3000, n);
        vt <= 1'h1;
        @(posedge clk);
        vt <= 1'h0;
        rd(`ATC_IDX_CTRL, q);
        chk("clear by vector", 8'h8B, q);
    endtask
    task automatic t_auto();
        int n;
        logic [7:0] q;
        for (int k = 1; k < 8; k++) begin
            wr(`ATC_IDX_TRIG, 8'(k));
            wr(`ATC_IDX_CTRL, 8'hB0);
            tf <= 7'h01 << (k - 1);
            wait_ss(400, n);
            chk("auto start", 1'h1, ss);
            tf <= 7'h00;
        end
        // Flag of the new source already high: the reselect is the edge
        @(posedge clk);
        tf <= 7'h02;
        wr(`ATC_IDX_TRIG, 8'h02);
        wait_ss(400, n);
        chk("reselect edge", 1'h1, ss);
        tf <= 7'h00;
        wr(`ATC_IDX_TRIG, 8'h00);
        wait_ss(200, n);
        chk("no free edge", 1'h0, ss);
        wr(`ATC_IDX_CTRL, 8'hE0);
        wait_ss(400, n);
        @(posedge clk);
        wait_ss(400, n);
        chk("free rerun", 1'h1, ss);
        rd(`ATC_IDX_CTRL, q);
        chk("free ctrl", 8'hF0, q);
        wr(`ATC_IDX_CTRL, 8'h10);
        wr(`ATC_IDX_TRIG, 8'h07);
        wr(`ATC_IDX_CTRL, 8'h90);
        tf <= 7'h7F;
        wait_ss(200, n);
        chk("no auto", 1'h0, ss);
        tf <= 7'h00;
    endtask
    task automatic t_abort();
        int n;
        logic [7:0] q;
        wr(`ATC_IDX_CTRL, 8'hC7);
        rd(`ATC_IDX_CTRL, q);
        chk("busy start", 8'hC7, q);
        wr(`ATC_IDX_CTRL, 8'h07);
        wait_ss(3400, n);
        chk("aborted", 1'h0, ss);
        rd(`ATC_IDX_CTRL, q);
        chk("off ctrl", {8'h07, 1'h0}, {q, pw});
    endtask
    task automatic give_verdict();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        t_regs();
        t_dis();
        t_conv();
        t_irq();
        t_auto();
        t_abort();
        give_verdict();
    end
    // Whole run needs about 4500 cycles
    initial begin
        #(40 * 20000);
        num_errors++;
        $display("mismatch watchdog exp finished got timeout");
        give_verdict();
    end
endmodule
